// file: rtl/pdcdiv_top.sv
// Purpose: power-of-two clock output divider with AXI4-Lite control
// Assumes: clk_i is the divider source clock; rst_i synchronous active high
// Notes:   bypass output is the source clock gated by a register, not a flop
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module pdcdiv_top (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  s_axil_awaddr_i,
	input  wire logic        s_axil_awvalid_i,
	output logic             s_axil_awready_o,
	input  wire logic [31:0] s_axil_wdata_i,
	input  wire logic [3:0]  s_axil_wstrb_i,
	input  wire logic        s_axil_wvalid_i,
	output logic             s_axil_wready_o,
	output logic [1:0]       s_axil_bresp_o,
	output logic             s_axil_bvalid_o,
	input  wire logic        s_axil_bready_i,
	input  wire logic [7:0]  s_axil_araddr_i,
	input  wire logic        s_axil_arvalid_i,
	output logic             s_axil_arready_o,
	output logic [31:0]      s_axil_rdata_o,
	output logic [1:0]       s_axil_rresp_o,
	output logic             s_axil_rvalid_o,
	input  wire logic        s_axil_rready_i,
	output logic             clock_output_pin_o
);
	import pdcdiv_pkg::*;

	typedef struct packed {
		logic                    aw_got;
		logic [7:0]              awaddr;
		logic                    w_got;
		logic [31:0]             wdata;
		logic [3:0]              wstrb;
		logic                    awready;
		logic                    wready;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    arready;
		logic                    rvalid;
		logic [31:0]             rdata;
		logic [1:0]              rresp;
		logic [PDCDIV_SEL_W-1:0] divide_select;
		logic                    run;
		logic                    divide_bypass;
		logic                    active;
		logic                    div_out;
	} pdcdiv_state_t;

	pdcdiv_state_t s_q;
	pdcdiv_state_t s_d;

	logic [PDCDIV_STAGES-1:0] stage_q;
	logic [PDCDIV_STAGES-1:0] stage_next;
	logic [PDCDIV_STAGES:0]   carry;
	logic                     count_en;
	logic                     tap_now;
	logic                     tap_next;
	logic [7:0]               wr_addr;
	logic                     wr_hit_ctrl;
	logic                     wr_hit_stat;
	logic                     rd_hit_ctrl;
	logic                     rd_hit_stat;
	logic [31:0]              ctrl_word;
	logic [31:0]              stat_word;

	// ----------------------------------------------------------------
	// sixteen-way tap selector
	// ----------------------------------------------------------------
	// the next-state tap feeds the output flop so the pin lines up with the chain
	always_comb begin
		tap_now  = 1'b0;
		tap_next = 1'b0;
		for (int i = 0; i < PDCDIV_STAGES; i++) begin
			if (s_q.divide_select == PDCDIV_SEL_W'(i)) begin
				tap_now  = stage_q[i];
				tap_next = stage_next[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// halving chain
	// ----------------------------------------------------------------
	// counting goes on while run is set, or while the selected tap is still high
	assign count_en = s_q.run | tap_now;
	assign carry[0] = count_en;

	genvar gi;
	generate
		for (gi = 0; gi < PDCDIV_STAGES; gi++) begin : g_stage
			pdcdiv_stage u_stage (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.carry_i (carry[gi]),
				.q_o     (stage_q[gi]),
				.next_o  (stage_next[gi]),
				.carry_o (carry[gi+1])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// address decode and read words
	// ----------------------------------------------------------------
	// the write address is the one taken this cycle, else the one held from before
	assign wr_addr     = (s_axil_awvalid_i && s_q.awready) ? s_axil_awaddr_i : s_q.awaddr;
	assign wr_hit_ctrl = (wr_addr[7:2] == PDCDIV_CTRL_OFS[7:2]);
	assign wr_hit_stat = (wr_addr[7:2] == PDCDIV_STAT_OFS[7:2]);
	assign rd_hit_ctrl = (s_axil_araddr_i[7:2] == PDCDIV_CTRL_OFS[7:2]);
	assign rd_hit_stat = (s_axil_araddr_i[7:2] == PDCDIV_STAT_OFS[7:2]);

	always_comb begin
		ctrl_word                                  = '0;
		ctrl_word[PDCDIV_SEL_LSB +: PDCDIV_SEL_W]  = s_q.divide_select;
		ctrl_word[PDCDIV_RUN_BIT]                  = s_q.run;
		ctrl_word[PDCDIV_BYP_BIT]                  = s_q.divide_bypass;
		stat_word                                  = '0;
		stat_word[PDCDIV_ACT_BIT]                  = s_q.active;
		stat_word[PDCDIV_OUT_BIT]                  = s_q.div_out;
		stat_word[PDCDIV_CNT_LSB +: PDCDIV_STAGES] = stage_q;
	end

	// ----------------------------------------------------------------
	// register bus and control state
	// ----------------------------------------------------------------
	always_comb begin
		logic aw_n;
		logic w_n;
		logic [31:0] wd;
		logic [3:0]  ws;
		aw_n = 1'b0;
		w_n  = 1'b0;
		wd   = '0;
		ws   = '0;
		s_d  = s_q;

		// write address and data are taken in either order
		if (s_axil_awvalid_i && s_q.awready) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = s_axil_awaddr_i;
		end
		if (s_axil_wvalid_i && s_q.wready) begin
			s_d.w_got = 1'b1;
			s_d.wdata = s_axil_wdata_i;
			s_d.wstrb = s_axil_wstrb_i;
		end
		aw_n = s_d.aw_got;
		w_n  = s_d.w_got;
		wd   = s_d.wdata;
		ws   = s_d.wstrb;

		// response handshake
		if (s_q.bvalid && s_axil_bready_i) begin
			s_d.bvalid = 1'b0;
		end
		if (aw_n && w_n) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = PDCDIV_RESP_OKAY;
			if (wr_hit_ctrl) begin
				if (ws[0]) begin
					s_d.divide_select = wd[PDCDIV_SEL_LSB +: PDCDIV_SEL_W];
					s_d.run           = wd[PDCDIV_RUN_BIT];
					s_d.divide_bypass = wd[PDCDIV_BYP_BIT];
				end
			end else if (!wr_hit_stat) begin
				s_d.bresp = PDCDIV_RESP_SLVERR;
			end
		end

		// read channel
		if (s_q.rvalid && s_axil_rready_i) begin
			s_d.rvalid = 1'b0;
		end
		if (s_axil_arvalid_i && s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = '0;
			s_d.rresp  = PDCDIV_RESP_OKAY;
			if (rd_hit_ctrl) begin
				s_d.rdata = ctrl_word;
			end else if (rd_hit_stat) begin
				s_d.rdata = stat_word;
			end else begin
				s_d.rresp = PDCDIV_RESP_SLVERR;
			end
		end

		// readies stay low while a response waits, so one write is open at a time
		s_d.awready = !s_d.aw_got && !s_d.bvalid;
		s_d.wready  = !s_d.w_got && !s_d.bvalid;
		s_d.arready = !s_d.rvalid;

		// registered tap: follows the selected stage, low once stopped
		s_d.active  = count_en;
		s_d.div_out = tap_next;
	end

	// one register for all control and bus state; the chain keeps its own flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q               <= '0;
			s_q.divide_select <= PDCDIV_SEL_RST;
			s_q.run           <= PDCDIV_RUN_RST;
			s_q.divide_bypass <= PDCDIV_BYP_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axil_awready_o   = s_q.awready;
	assign s_axil_wready_o    = s_q.wready;
	assign s_axil_bvalid_o    = s_q.bvalid;
	assign s_axil_bresp_o     = s_q.bresp;
	assign s_axil_arready_o   = s_q.arready;
	assign s_axil_rvalid_o    = s_q.rvalid;
	assign s_axil_rdata_o     = s_q.rdata;
	assign s_axil_rresp_o     = s_q.rresp;
	// bypass needs the full-rate clock, which no flop can reproduce
	assign clock_output_pin_o = s_q.divide_bypass ? clk_i : s_q.div_out;
endmodule

// file: rtl/pdcdiv_pkg.sv
// Purpose: constants for the power-of-two clock output divider
// Assumes: 32-bit AXI4-Lite register access, one clock (divider source clock)
// Notes:   rules carried by the divider
package pdcdiv_pkg;
	localparam int          PDCDIV_STAGES     = 16;
	localparam int          PDCDIV_SEL_W      = 4;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  PDCDIV_CTRL_OFS   = 8'h00;
	localparam logic [7:0]  PDCDIV_STAT_OFS   = 8'h04;
	localparam int          PDCDIV_SEL_LSB    = 0;
	localparam int          PDCDIV_RUN_BIT    = 4;
	localparam int          PDCDIV_BYP_BIT    = 5;
	localparam int          PDCDIV_ACT_BIT    = 0;
	localparam int          PDCDIV_OUT_BIT    = 1;
	localparam int          PDCDIV_CNT_LSB    = 16;
	localparam logic [3:0]  PDCDIV_SEL_RST    = 4'h0;
	localparam logic        PDCDIV_RUN_RST    = 1'b0;
	localparam logic        PDCDIV_BYP_RST    = 1'b0;
	localparam logic [1:0]  PDCDIV_RESP_OKAY  = 2'h0;
	localparam logic [1:0]  PDCDIV_RESP_SLVERR = 2'h2;
endpackage

// file: rtl/pdcdiv_stage.sv
// Purpose: one halving stage of the divider chain
// Assumes: carry_i high when every lower stage is high and counting is on
// Notes:   toggles on carry, so each stage runs at half the rate of the one below
`timescale 1ns/1ps
module pdcdiv_stage (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic carry_i,
	output logic      q_o,
	output logic      next_o,
	output logic      carry_o
);
	import pdcdiv_pkg::*;

	typedef struct packed {
		logic q;
	} pdcdiv_stage_t;

	pdcdiv_stage_t s_q;
	pdcdiv_stage_t s_d;

	always_comb begin
		s_d   = s_q;
		s_d.q = s_q.q ^ carry_i;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q_o     = s_q.q;
	assign next_o  = s_d.q;
	assign carry_o = s_q.q & carry_i;
endmodule

// file: sim/pdcdiv_chk.sv
// Purpose: bus and reset checks at the divider ports
// Assumes: bound into pdcdiv_top, one clock
// Notes:   covers mark the main traffic
`timescale 1ns/1ps
module pdcdiv_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        s_axil_awvalid_i,
	input wire logic        s_axil_awready_o,
	input wire logic        s_axil_wvalid_i,
	input wire logic        s_axil_wready_o,
	input wire logic [1:0]  s_axil_bresp_o,
	input wire logic        s_axil_bvalid_o,
	input wire logic        s_axil_bready_i,
	input wire logic        s_axil_arvalid_i,
	input wire logic        s_axil_arready_o,
	input wire logic [31:0] s_axil_rdata_o,
	input wire logic        s_axil_rvalid_o,
	input wire logic        s_axil_rready_i,
	input wire logic        clock_output_pin_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_rst_clear: assert property (disable iff (1'b0) rst_i |=> !clock_output_pin_o && !s_axil_bvalid_o)
		else $error("pin or bvalid set after reset");
	a_b_answer: assert property (s_axil_awvalid_i && s_axil_awready_o && s_axil_wvalid_i && s_axil_wready_o
		|=> s_axil_bvalid_o) else $error("write response late");
	a_b_hold: assert property (s_axil_bvalid_o && !s_axil_bready_i |=> s_axil_bvalid_o && $stable(s_axil_bresp_o))
		else $error("write response moved");
	a_b_drop: assert property (s_axil_bvalid_o && s_axil_bready_i |=> !s_axil_bvalid_o) else $error("bvalid stuck");
	a_aw_block: assert property (s_axil_bvalid_o |-> !s_axil_awready_o && !s_axil_wready_o)
		else $error("ready during response");
	a_r_answer: assert property (s_axil_arvalid_i && s_axil_arready_o |=> s_axil_rvalid_o) else $error("read late");
	a_r_hold: assert property (s_axil_rvalid_o && !s_axil_rready_i |=> s_axil_rvalid_o && $stable(s_axil_rdata_o))
		else $error("read data moved");
	a_ar_block: assert property (s_axil_rvalid_o |-> !s_axil_arready_o) else $error("arready while rvalid");
	c_write: cover property (s_axil_bvalid_o && s_axil_bready_i);
	c_read: cover property (s_axil_rvalid_o && s_axil_rready_i);
	c_pin: cover property ($rose(clock_output_pin_o));
endmodule
bind pdcdiv_top pdcdiv_chk pdcdiv_chk_i (.*);

// file: sim/pdcdiv_pin_model.sv
// Purpose: receiver on the clock output pin
// Assumes: pin sampled on clk_i rising edges
// Notes:   period_o is clk cycles between the last two rises
`timescale 1ns/1ps
module pdcdiv_pin_model (
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	input  wire logic  pin_i,
	output logic [31:0] period_o,
	output logic [31:0] rises_o
);
	logic        prev_q;
	logic [31:0] cnt_q;
	always_ff @(posedge clk_i) begin
		prev_q <= pin_i;
		cnt_q <= (pin_i && !prev_q) ? 32'h1 : cnt_q + 32'h1;
		if (rst_i) begin
			period_o <= 32'h0;
			rises_o <= 32'h0;
		end else if (pin_i && !prev_q) begin
			period_o <= cnt_q;
			rises_o <= rises_o + 32'h1;
		end
	end
endmodule

// file: sim/pdcdiv_tb_top.sv
// Purpose: register and clock output tests for the divider
// Assumes: 40 MHz clock, AXI4-Lite master tasks
// Notes:   pin periods come from the pin model
`timescale 1ns/1ps
module pdcdiv_tb_top;
	logic        clk_i = 0, rst_i = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic        awr, wrdy, bv, arr, rv, pin;
	logic [7:0]  aw = 0, ar = 0;
	logic [3:0]  ws = 0;
	logic [1:0]  bresp, rresp;
	logic [31:0] wd = 0, rd, per, rises, r0;
	int          err_count = 0, samples_checked = 0, cyc = 0;
	pdcdiv_top pdcdiv_top_i (.clk_i, .rst_i, .s_axil_awaddr_i(aw), .s_axil_awvalid_i(awv), .s_axil_awready_o(awr),
		.s_axil_wdata_i(wd), .s_axil_wstrb_i(ws), .s_axil_wvalid_i(wv), .s_axil_wready_o(wrdy), .s_axil_bresp_o(bresp),
		.s_axil_bvalid_o(bv), .s_axil_bready_i(br), .s_axil_araddr_i(ar), .s_axil_arvalid_i(arv), .s_axil_arready_o(arr),
		.s_axil_rdata_o(rd), .s_axil_rresp_o(rresp), .s_axil_rvalid_o(rv), .s_axil_rready_i(rr), .clock_output_pin_o(pin));
	pdcdiv_pin_model pdcdiv_pin_model_i (.clk_i, .rst_i, .pin_i(pin), .period_o(per), .rises_o(rises));
	initial forever #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("mismatches=%0d checks=%0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic pinchk(input logic e);
		chk({31'h0, pin}, {31'h0, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
		@(posedge clk_i);
		aw <= a;
		wd <= d;
		ws <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrdy) wv <= 1'b0;
		end while (!bv);
		br <= 1'b0;
		chk({30'h0, bresp}, {30'h0, e});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge clk_i);
		ar <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arv && arr) arv <= 1'b0;
		end while (!rv);
		rr <= 1'b0;
		chk(rd, d);
		chk({30'h0, rresp}, {30'h0, e});
	endtask
	task automatic runchk(input logic [3:0] n);
		wr(8'h00, {27'h0, 1'b1, n}, 4'h1, 2'h0);
		r0 = rises;
		while (rises < r0 + 3) @(posedge clk_i);
		chk(per, 32'h2 << n);
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		pinchk(1'b0);
		rdc(8'h00, 32'h0, 2'h0);
		rdc(8'h04, 32'h0, 2'h0);
		rdc(8'h08, 32'h0, 2'h2);
		wr(8'h08, 32'h3F, 4'hF, 2'h2);
		for (int i = 0; i < 4; i++) runchk(4'(9 - 3 * i));
		wr(8'h00, 32'h3F, 4'h0, 2'h0);
		wr(8'h04, 32'h0, 4'hF, 2'h0);
		rdc(8'h00, 32'h10, 2'h0);
		wr(8'h00, 32'h13, 4'h1, 2'h0);
		wait (pin);
		wr(8'h00, 32'h03, 4'h1, 2'h0);
		repeat (12) @(posedge clk_i);
		repeat (16) @(negedge clk_i) pinchk(1'b0);
		for (int b = 2; b < 4; b++) begin
			wr(8'h00, {26'h0, b[1:0], 4'h0}, 4'hF, 2'h0);
			@(posedge clk_i);
			#5 pinchk(1'b1);
			@(negedge clk_i);
			#5 pinchk(1'b0);
		end
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		pinchk(1'b0);
		rdc(8'h00, 32'h0, 2'h0);
		rdc(8'h04, 32'h0, 2'h0);
		tally_and_finish();
	end
endmodule
